// ==== hdl/pies_defs.vh ====
`ifndef PIES_DEFS_VH
`define PIES_DEFS_VH
`define PIES_OFS_CAPT_EN 8'h00
`define PIES_OFS_MISC_EN 8'h04
`define PIES_OFS_MEAS_EN 8'h08
`define PIES_OFS_FLAGS 8'h0C
`define PIES_OFS_CTRL 8'h10
`define PIES_OFS_EVT_STAT 8'h14
`define PIES_OFS_EVT_MASK 8'h18
`define PIES_OFS_REQ_STAT 8'h1C
`define PIES_CAPT_MASK 8'h1F
`define PIES_MISC_MASK 8'hF7
`define PIES_MEAS_MASK 8'h3F
`define PIES_FLAGS_WMASK 8'h21
`define PIES_BIT_TMR0 5
`define PIES_BIT_CHG 4
`define PIES_BIT_EXT 0
`define PIES_BIT_GATE 0
`define PIES_EVT_TMR0 0
`define PIES_EVT_EXT 1
`define PIES_EVT_CHG 2
`define PIES_EVT_REQ 3
`define PIES_RESET_BYTE 8'h00
`define PIES_RESP_OKAY 2'b00
`define PIES_RESP_SLVERR 2'b10
`endif

// ==== hdl/pies_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pies_defs.vh"
// Operation
// R1: capture enables, units 1-5 at bits 0-4
// R2: unimplemented bits read zero, ignore writes
// R3: misc bit7 scanner, bit6 checksum enables
// R4: misc bit5 memwrite done, bit4 oscillator
// R5: misc bits 2..0 waveform gens 3..1
// R6: global gate required for any peripheral request
// R7: measure low bits timer1 overflow/period/width
// R8: measure bits 3..5 timer2 enables
// R9: timer0 overflow sets sticky flag bit5
// R10: bit4 is OR of port change flags
// R11: external event sets sticky flag bit0
// R12: external pin chosen by select input
// R13: all bits reset to zero
// R14: request is OR of flag and enable, gated
module pies_top #(
  parameter NPINS = 8,
  parameter SELW = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  output reg s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output reg s_axil_wready,
  output reg [1:0] s_axil_bresp,
  output reg s_axil_bvalid,
  input wire s_axil_bready,
  input wire [31:0] s_axil_araddr,
  input wire s_axil_arvalid,
  output reg s_axil_arready,
  output reg [31:0] s_axil_rdata,
  output reg [1:0] s_axil_rresp,
  output reg s_axil_rvalid,
  input wire s_axil_rready,
  input wire [4:0] capture_src,
  input wire [6:0] misc_src,
  input wire [5:0] meas_src,
  input wire timer_zero_overflow,
  input wire [4:0] port_change_flags,
  input wire [NPINS-1:0] ext_pins,
  input wire [SELW-1:0] ext_irq_pin_select,
  input wire global_periph_gate,
  output reg periph_irq_req,
  output reg core_irq_req,
  output reg irq
);
  reg [7:0] capture_irq_enables_reg;
  reg [7:0] misc_periph_irq_enables_reg;
  reg [7:0] measure_timer_irq_enables_reg;
  reg timer_zero_overflow_flag_reg;
  reg external_pin_irq_flag_reg;
  reg pin_change_summary_flag_reg;
  reg ext_rise_req_reg;
  reg [3:0] evt_stat_reg;
  reg [3:0] evt_mask_reg;
  reg [2:0] ext_sync_reg;
  reg ext_prev_reg;
  reg [31:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg periph_req_prev_reg;
  reg [7:0] flags_rd;
  reg [31:0] rd_next;
  reg rd_err;
  wire ext_in;
  wire ext_level;
  wire ext_rise;
  wire [7:0] misc_src_map;
  wire any_enabled;
  wire periph_req_next;
  wire core_req_next;
  wire do_write;
  wire wr_capt;
  wire wr_misc;
  wire wr_meas;
  wire wr_flags;
  wire wr_ctrl;
  wire wr_mask;
  wire wr_known;
  wire do_read;
  wire rd_evt;
  wire [3:0] evt_set;

  assign ext_in = ext_pins[ext_irq_pin_select]; // R12
  // stage 1 only feeds stage 2; the edge waits until stages 2 and 3 agree high
  assign ext_level = ext_sync_reg[1] & ext_sync_reg[2];
  assign ext_rise = ext_level & ~ext_prev_reg;
  assign misc_src_map = {misc_src[6:3], 1'b0, misc_src[2:0]};

  assign any_enabled = |(capture_src & capture_irq_enables_reg[4:0]) | // R1
    |(misc_src_map & misc_periph_irq_enables_reg) | // R3 R4 R5
    |(meas_src & measure_timer_irq_enables_reg[5:0]); // R7 R8
  assign periph_req_next = any_enabled & global_periph_gate; // R6 R14
  assign core_req_next = timer_zero_overflow_flag_reg | external_pin_irq_flag_reg |
    pin_change_summary_flag_reg;

  assign do_write = aw_have_reg & w_have_reg & ~s_axil_bvalid;
  // upper address bits set: answered with an error, nothing lands
  assign wr_capt = do_write && wr_known && awaddr_reg[7:0] == `PIES_OFS_CAPT_EN;
  assign wr_misc = do_write && wr_known && awaddr_reg[7:0] == `PIES_OFS_MISC_EN;
  assign wr_meas = do_write && wr_known && awaddr_reg[7:0] == `PIES_OFS_MEAS_EN;
  assign wr_flags = do_write && wr_known && awaddr_reg[7:0] == `PIES_OFS_FLAGS;
  assign wr_ctrl = do_write && wr_known && awaddr_reg[7:0] == `PIES_OFS_CTRL;
  assign wr_mask = do_write && wr_known && awaddr_reg[7:0] == `PIES_OFS_EVT_MASK;
  assign wr_known = (awaddr_reg[31:5] == 27'h0) && (awaddr_reg[4:0] != 5'h14) && (awaddr_reg[1:0] == 2'b00) &&
    (awaddr_reg[4:0] != 5'h1C);
  assign do_read = s_axil_arvalid & s_axil_arready;
  assign rd_evt = do_read && s_axil_araddr[7:0] == `PIES_OFS_EVT_STAT && !rd_err;
  assign evt_set = {periph_req_next & ~periph_req_prev_reg, pin_change_summary_flag_reg,
    ext_rise, timer_zero_overflow};

  always @* begin
    flags_rd = `PIES_RESET_BYTE; // R2
    flags_rd[`PIES_BIT_TMR0] = timer_zero_overflow_flag_reg;
    flags_rd[`PIES_BIT_CHG] = pin_change_summary_flag_reg;
    flags_rd[`PIES_BIT_EXT] = external_pin_irq_flag_reg;
  end

  always @* begin
    rd_next = 32'h00000000;
    rd_err = 1'b0;
    if (s_axil_araddr[31:8] != 24'h000000 || s_axil_araddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (s_axil_araddr[7:0] == `PIES_OFS_CAPT_EN) begin
      rd_next = {24'h000000, capture_irq_enables_reg};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_MISC_EN) begin
      rd_next = {24'h000000, misc_periph_irq_enables_reg};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_MEAS_EN) begin
      rd_next = {24'h000000, measure_timer_irq_enables_reg};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_FLAGS) begin
      rd_next = {24'h000000, flags_rd};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_CTRL) begin
      rd_next = {31'h00000000, global_periph_gate};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_EVT_STAT) begin
      rd_next = {28'h0000000, evt_stat_reg};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_EVT_MASK) begin
      rd_next = {28'h0000000, evt_mask_reg};
    end else if (s_axil_araddr[7:0] == `PIES_OFS_REQ_STAT) begin
      rd_next = {29'h00000000, irq, core_irq_req, periph_irq_req};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_reg <= 3'b000;
      ext_prev_reg <= 1'b0;
      periph_req_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_in};
      if (ext_sync_reg[1] == ext_sync_reg[2]) begin
        ext_prev_reg <= ext_sync_reg[2];
      end
      periph_req_prev_reg <= periph_req_next;
    end
  end

  // write channel: address and data latched independently, either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `PIES_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        awaddr_reg <= s_axil_awaddr;
        aw_have_reg <= 1'b1;
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        wdata_reg <= s_axil_wdata;
        wstrb_reg <= s_axil_wstrb;
        w_have_reg <= 1'b1;
        s_axil_wready <= 1'b0;
      end
      if (do_write) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_known ? `PIES_RESP_OKAY : `PIES_RESP_SLVERR;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h00000000;
      s_axil_rresp <= `PIES_RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axil_arready <= 1'b0;
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_next;
        s_axil_rresp <= rd_err ? `PIES_RESP_SLVERR : `PIES_RESP_OKAY;
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
        s_axil_arready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      capture_irq_enables_reg <= `PIES_RESET_BYTE; // R13
      misc_periph_irq_enables_reg <= `PIES_RESET_BYTE;
      measure_timer_irq_enables_reg <= `PIES_RESET_BYTE;
      timer_zero_overflow_flag_reg <= 1'b0;
      external_pin_irq_flag_reg <= 1'b0;
      pin_change_summary_flag_reg <= 1'b0;
      evt_mask_reg <= 4'h0;
      evt_stat_reg <= 4'h0;
    end else begin
      if (wr_capt && wstrb_reg[0]) begin
        capture_irq_enables_reg <= wdata_reg[7:0] & `PIES_CAPT_MASK; // R1 R2
      end
      if (wr_misc && wstrb_reg[0]) begin
        misc_periph_irq_enables_reg <= wdata_reg[7:0] & `PIES_MISC_MASK; // R2 R3 R4 R5
      end
      if (wr_meas && wstrb_reg[0]) begin
        measure_timer_irq_enables_reg <= wdata_reg[7:0] & `PIES_MEAS_MASK; // R2 R7 R8
      end
      if (wr_mask && wstrb_reg[0]) begin
        evt_mask_reg <= wdata_reg[3:0];
      end
      // hardware set wins over a software write in the same cycle
      if (timer_zero_overflow) begin
        timer_zero_overflow_flag_reg <= 1'b1; // R9
      end else if (wr_flags && wstrb_reg[0]) begin
        timer_zero_overflow_flag_reg <= wdata_reg[`PIES_BIT_TMR0]; // R9
      end
      if (ext_rise) begin
        external_pin_irq_flag_reg <= 1'b1; // R11
      end else if (wr_flags && wstrb_reg[0]) begin
        external_pin_irq_flag_reg <= wdata_reg[`PIES_BIT_EXT]; // R11
      end
      pin_change_summary_flag_reg <= |port_change_flags; // R10
      // read clears; a new event in the read cycle stays set
      evt_stat_reg <= (rd_evt ? 4'h0 : evt_stat_reg) | evt_set;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      periph_irq_req <= 1'b0;
      core_irq_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      periph_irq_req <= periph_req_next; // R6 R14
      core_irq_req <= core_req_next;
      irq <= |(evt_stat_reg & evt_mask_reg);
    end
  end
endmodule
`default_nettype wire

// ==== testbench/pies_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module pies_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic [4:0] capture_src,
  input wire logic [6:0] misc_src,
  input wire logic [5:0] meas_src,
  input wire logic timer_zero_overflow,
  input wire logic [4:0] port_change_flags,
  input wire logic global_periph_gate,
  input wire logic periph_irq_req,
  input wire logic core_irq_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axil_arvalid && s_axil_arready;
  endsequence
  sequence s_wr_take;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  a_read_answer: assert property (s_rd_take |=> s_axil_rvalid) else $error("read not answered");
  a_read_refuse: assert property (s_axil_rvalid |-> !s_axil_arready) else $error("address taken while busy");
  a_write_answer: assert property (s_wr_take |=> ##1 s_axil_bvalid) else $error("write not answered");
  a_write_refuse: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready) else $error("write taken busy");
  a_gate_blocks: assert property (!global_periph_gate |=> !periph_irq_req) else $error("request without gate");
  a_no_source: assert property (capture_src == 5'h00 && misc_src == 7'h00 && meas_src == 6'h00
    |=> !periph_irq_req) else $error("request without source");
  a_tmr0_flag: assert property (timer_zero_overflow |-> ##2 core_irq_req) else $error("overflow not flagged");
  a_chg_flag: assert property (port_change_flags != 5'h00 |-> ##2 core_irq_req) else $error("change not flagged");
endmodule
bind pies_top pies_monitor u_pies_monitor (.aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid),
  .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready),
  .s_axil_bvalid(s_axil_bvalid), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rvalid(s_axil_rvalid), .capture_src(capture_src), .misc_src(misc_src), .meas_src(meas_src),
  .timer_zero_overflow(timer_zero_overflow), .port_change_flags(port_change_flags),
  .global_periph_gate(global_periph_gate), .periph_irq_req(periph_irq_req), .core_irq_req(core_irq_req));
`default_nettype wire

// ==== testbench/pies_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pies_core_model #(parameter int LAT = 3) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  output logic [15:0] n_taken
);
  int wait_cnt;
  // a slow core only services a request still held after LAT cycles
  always @(posedge aclk) begin
    if (!aresetn) begin
      n_taken <= 16'h0000;
      wait_cnt <= 0;
    end else if (req) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == LAT) n_taken <= n_taken + 16'h0001;
    end else wait_cnt <= 0;
  end
endmodule
`default_nettype wire

// ==== testbench/test_peripheral_irq_enable_status.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pies_defs.vh"
module test_peripheral_irq_enable_status;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, seed = 32'h0DCA4803, r, en;
  logic [4:0] cap = 5'h00, pcf = 5'h00;
  logic [6:0] misc = 7'h00;
  logic [5:0] meas = 6'h00;
  logic [7:0] pins = 8'h00;
  logic [2:0] psel = 3'h5;
  logic t0 = 1'b0, gate = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, preq, creq, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] n_taken;
  logic [65:0] rq[$], hd;
  logic [1:0] bq[$];
  int errors = 0, n_compared = 0;
  pies_top u_pies_top (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .capture_src(cap), .misc_src(misc),
    .meas_src(meas), .timer_zero_overflow(t0), .port_change_flags(pcf), .ext_pins(pins),
    .ext_irq_pin_select(psel), .global_periph_gate(gate), .periph_irq_req(preq), .core_irq_req(creq), .irq(irq));
  pies_core_model u_pies_core_model (.aclk(aclk), .aresetn(aresetn), .req(irq), .n_taken(n_taken));
  initial forever #2 aclk = ~aclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
    input logic [1:0] er = 2'b00);
    rq.push_back({m, e, er});
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // output is read after the wait, not when the task is called
  task automatic lvl(input string nm, input logic e, input int s);
    repeat (4) @(posedge aclk);
    chk(nm, {33'h0, e}, {33'h0, (s != 0) ? irq : preq});
  endtask
  // results are matched in arrival order; one transfer in flight at a time
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      hd = rq.pop_front();
      chk("rdata", {hd[1:0], hd[33:2] & hd[65:34]}, {rresp, rdata & hd[65:34]});
    end
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end
  task automatic wrap_up();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(32'(i * 4), 32'h0);
    for (int i = 0; i < 4; i++) wr(32'(i * 4), 32'hFFFFFFFF);
    rd(8'h00, 32'h1F);
    rd(8'h04, 32'hF7);
    rd(8'h08, 32'h3F);
    rd(8'h0C, 32'h21);
    for (int k = 0; k < 24; k++) begin
      r = xs();
      en = xs();
      for (int i = 0; i < 3; i++) wr(32'(i * 4), {24'h0, en[i*8+:8]});
      {gate, meas, misc, cap} <= {r[18] | r[19], r[17:0]};
      lvl("periph_irq_req", (r[18] | r[19]) & |{r[4:0] & en[4:0], r[11:5] & {en[15:12], en[10:8]},
        r[17:12] & en[21:16]}, 0);
    end
    {gate, meas, misc, cap} <= 19'h40000;
    wr(8'h0C, 32'h0);
    rd(8'h10, 32'h1);
    rd(8'h14, 32'h0, 32'h0);
    wr(8'h18, 32'h1);
    @(posedge aclk);
    t0 <= 1'b1;
    @(posedge aclk);
    t0 <= 1'b0;
    lvl("irq", 1'b1, 1);
    rd(8'h0C, 32'h20);
    chk("core_irq_req", {33'h0, 1'b1}, {33'h0, creq});
    wr(8'h18, 32'h0);
    lvl("irq", 1'b0, 1);
    wr(8'h18, 32'h1);
    lvl("irq", 1'b1, 1);
    rd(8'h14, 32'h1, 32'h1);
    lvl("irq", 1'b0, 1);
    chk("core_model", {33'h0, 1'b1}, {33'h0, |n_taken});
    rd(8'h0C, 32'h20);
    wr(8'h0C, 32'h0);
    pins <= 8'h08;
    repeat (8) @(posedge aclk);
    rd(8'h0C, 32'h0);
    pins <= 8'h28;
    repeat (8) @(posedge aclk);
    rd(8'h0C, 32'h1);
    wr(8'h0C, 32'h0);
    pcf <= 5'h04;
    wr(8'h0C, 32'h0);
    rd(8'h0C, 32'h10);
    pcf <= 5'h00;
    rd(8'h0C, 32'h0);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, `PIES_RESP_SLVERR);
    wr(8'h1C, 32'h7, `PIES_RESP_SLVERR);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
